/* File: tb.sv */
// Self-checking testbench for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none

module tb;
  import timer_pkg::*;

  logic       sys_clk;
  logic       rst_n;
  logic       cpu_irq_mask;
  logic       timer_irq;
  logic       ext_pin;
  logic       err;
  logic [1:0] cap_pin;
  logic [1:0] cmp_pin;
  logic [1:0] cmp_oe;
  logic [1:0] pad;
  apb_req_s   req;
  apb_rsp_s   rsp;
  int         mismatches;
  int         compares;

  timer_capture_compare_one_pulse dut_u (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .apb_req                  (req),
    .apb_rsp                  (rsp),
    .capture_pin              (cap_pin),
    .external_timer_clock_pin (ext_pin),
    .compare_out_pin          (cmp_pin),
    .compare_out_pin_oe       (cmp_oe),
    .cpu_irq_mask             (cpu_irq_mask),
    .timer_irq                (timer_irq)
  );

  timer_pin_partner pins_u (
    .sys_clk                  (sys_clk),
    .capture_pin              (cap_pin),
    .external_timer_clock_pin (ext_pin),
    .compare_out_pin          (cmp_pin),
    .compare_out_pin_oe       (cmp_oe),
    .pad_level                (pad)
  );

  always #50 sys_clk = ~sys_clk;

  // ****************************************************************
  // Bus and check helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic apb(input logic wnr, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wnr, paddr: a,
             pwdata: {24'h0, d}};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    chk("pready", 16'h1, {15'h0, rsp.pready});
    r = rsp.prdata[7:0];
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    apb(1'b0, a, 8'h00, r);
  endtask

  // High byte first: it locks the capture until the low byte
  task automatic rd16(input int ch, output logic [15:0] v);
    rd(ADDR_CAP_HIGH[ch], v[15:8]);
    rd(ADDR_CAP_LOW[ch], v[7:0]);
  endtask

  task automatic wait_pin(input int ch, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cmp_pin[ch] !== lvl && n < 400);
  endtask

  task automatic tog_mask();
    @(posedge sys_clk);
    cpu_irq_mask <= ~cpu_irq_mask;
    @(posedge sys_clk);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] v;
    chk("outs", 16'h0, {11'h0, timer_irq, cmp_pin, cmp_oe});
    rd(ADDR_CMP1_HIGH, v);
    chk("cmp1 high", 16'h80, {8'h0, v});
    rd(ADDR_CMP2_HIGH, v);
    chk("cmp2 high", 16'h80, {8'h0, v});
    rd(ADDR_CMP2_LOW, v);
    chk("cmp2 low", 16'h0, {8'h0, v});
    rd(8'hfc, v);
    chk("unmapped", 16'h100, {7'h0, err, v});
    $display("test reset done");
  endtask

  task automatic t_compare();
    logic [7:0] v;
    int n;
    wr(ADDR_CMP1_HIGH, 8'h00);
    wr(ADDR_CMP1_LOW, 8'h40);
    wr(ADDR_CMP2_HIGH, 8'h00);
    wr(ADDR_CMP2_LOW, 8'h40);
    wr(ADDR_CTRL_ONE, 8'h43);
    wr(ADDR_CTRL_TWO, 8'h84);
    wr(ADDR_CNT_LOW, 8'h00);
    wait_pin(0, 1'b1, n);
    chk("div2 match", 16'h1, {15'h0, n >= 135 && n <= 136});
    chk("irq", 16'h1, {15'h0, timer_irq});
    chk("pin2", 16'h1, {13'h0, cmp_oe[1], cmp_pin[1], pad[1]});
    tog_mask();
    chk("masked irq", 16'h0, {15'h0, timer_irq});
    tog_mask();
    rd(ADDR_CMP1_LOW, v);
    chk("cmp1 low", 16'h40, {8'h0, v});
    rd(ADDR_STATUS, v);
    chk("unarmed", 16'h48, {8'h0, v});
    rd(ADDR_CMP1_LOW, v);
    wr(ADDR_CMP2_LOW, 8'h40);
    rd(ADDR_STATUS, v);
    chk("cleared", 16'h0, {8'h0, v});
    $display("test compare done");
  endtask

  task automatic t_capture();
    logic [7:0] h;
    logic [7:0] l;
    logic [15:0] v1;
    logic [15:0] v2;
    wr(ADDR_CTRL_ONE, 8'h84);
    pins_u.set_cap(0, 1'b1);
    chk("cap irq", 16'h1, {15'h0, timer_irq});
    rd(ADDR_STATUS, l);
    chk("cap1 flag", 16'h80, {8'h0, l});
    rd16(0, v1);
    rd(ADDR_STATUS, l);
    chk("cap1 cleared", 16'h0, {8'h0, l});
    pins_u.set_cap(0, 1'b0);
    pins_u.set_cap(1, 1'b1);
    rd(ADDR_STATUS, l);
    chk("inactive", 16'h0, {8'h0, l});
    pins_u.set_cap(1, 1'b0);
    rd(ADDR_STATUS, l);
    chk("cap2 fall", 16'h10, {8'h0, l});
    rd(ADDR_CAP2_LOW, l);
    pins_u.set_cap(0, 1'b1);
    rd16(0, v2);
    chk("newer", 16'h1, {15'h0, v2 > v1});
    rd(ADDR_STATUS, l);
    rd(ADDR_CAP1_LOW, l);
    rd(ADDR_CAP1_HIGH, h);
    pins_u.set_cap(0, 1'b0);
    pins_u.set_cap(0, 1'b1);
    rd(ADDR_STATUS, l);
    chk("locked flag", 16'h0, {8'h0, l});
    rd(ADDR_CAP1_LOW, l);
    chk("locked value", v2, {h, l});
    $display("test capture done");
  endtask

  task automatic t_force();
    logic [7:0] v;
    int n;
    wr(ADDR_CTRL_ONE, 8'h08);
    wait_pin(0, 1'b0, n);
    chk("forced low", 16'h1, {15'h0, n <= 2});
    wr(ADDR_CTRL_ONE, 8'h09);
    wait_pin(0, 1'b1, n);
    chk("forced high", 16'h1, {15'h0, n <= 2});
    rd(ADDR_STATUS, v);
    chk("no flag", 16'h0, {8'h0, v});
    wr(ADDR_CTRL_TWO, 8'ha4);
    wr(ADDR_CTRL_ONE, 8'h08);
    rd(ADDR_STATUS, v);
    chk("force in pulse", 16'h1, {15'h0, cmp_pin[0]});
    $display("test force done");
  endtask

  task automatic t_pulse();
    logic [7:0] v;
    logic [15:0] c;
    int n;
    wr(ADDR_CTRL_ONE, 8'h05);
    pins_u.set_cap(0, 1'b0);
    pins_u.set_cap(0, 1'b1);
    chk("pulse start", 16'h0, {15'h0, cmp_pin[0]});
    wait_pin(0, 1'b1, n);
    chk("pulse end", 16'h1, {15'h0, n >= 130 && n <= 136});
    rd(ADDR_STATUS, v);
    chk("pulse flags", 16'h88, {8'h0, v});
    rd16(0, c);
    chk("pulse capture", 16'hfffd, c);
    rd(ADDR_CMP2_LOW, v);
    wr(ADDR_CTRL_TWO, 8'hb4);
    pins_u.set_cap(0, 1'b0);
    pins_u.set_cap(0, 1'b1);
    chk("pwm wins", 16'h1, {15'h0, cmp_pin[0]});
    rd(ADDR_STATUS, v);
    chk("no cap1", 16'h0, {8'h0, v});
    $display("test one-pulse done");
  endtask

  // Divide-by-eight flags one count late; a high write inhibits compare
  task automatic t_slow();
    logic [7:0] v;
    int n;
    wr(ADDR_CTRL_TWO, 8'h88);
    wr(ADDR_CTRL_ONE, 8'h08);
    wr(ADDR_CTRL_ONE, 8'h01);
    wr(ADDR_CMP1_LOW, 8'h02);
    wr(ADDR_CMP1_HIGH, 8'h00);
    wr(ADDR_CNT_LOW, 8'h00);
    repeat (64) @(posedge sys_clk);
    chk("locked compare", 16'h0, {15'h0, cmp_pin[0]});
    wr(ADDR_CMP1_LOW, 8'h02);
    wr(ADDR_CNT_LOW, 8'h00);
    wait_pin(0, 1'b1, n);
    chk("div8 match", 16'h1, {15'h0, n >= 49 && n <= 56});
    rd(ADDR_STATUS, v);
    chk("div8 flag", 16'h40, {8'h0, v});
    $display("test slow clock done");
  endtask

  task automatic t_ext();
    logic [7:0] a;
    logic [7:0] b;
    wr(ADDR_CTRL_TWO, 8'h8d);
    rd(ADDR_CNT_LOW, a);
    pins_u.ext_pulses(5);
    rd(ADDR_CNT_LOW, b);
    chk("ext count", 16'h5, {8'h0, b - a});
    $display("test external clock done");
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 100);
    mismatches++;
    conclude();
  end

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    cpu_irq_mask = 1'b0;
    req = '0;
    err = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_compare();
    t_capture();
    t_force();
    t_pulse();
    t_slow();
    t_ext();
    conclude();
  end
endmodule

`default_nettype wire

/* File: timer_capture_compare_one_pulse.sv */
// Capture, compare and one-pulse timer with an APB register slave
`timescale 1ns/10ps
`default_nettype none

module timer_capture_compare_one_pulse
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // APB slave
  input  wire timer_pkg::apb_req_s apb_req,
  output var  timer_pkg::apb_rsp_s apb_rsp,
  // Timer pins
  input  wire logic [1:0]          capture_pin,
  input  wire logic                external_timer_clock_pin,
  output logic [1:0]               compare_out_pin,
  output logic [1:0]               compare_out_pin_oe,
  // Interrupt request
  input  wire logic                cpu_irq_mask,
  output logic                     timer_irq
);

  import timer_pkg::*;

  // ****************************************************************
  // State and decode
  // ****************************************************************
  timer_state_s q;
  timer_state_s d;

  logic              setup;
  logic              acc;
  logic              wr;
  logic              rd;
  logic [7:0]        addr;
  logic [7:0]        rdata;
  logic              mapped;
  logic [1:0]        clk_sel;
  logic              tick;
  logic              ext_edge;
  logic [15:0]       cnt_inc;
  logic              pwm_active;
  logic              opm_active;
  logic              capture_off;
  logic              opm_fire;
  logic              cnt_low_wr;
  logic              force_allowed;
  logic [1:0]        cap_edge;
  logic [1:0]        cap_fire;
  logic [1:0]        cmp_hit;
  logic [1:0]        cap_low_acc;
  logic [1:0]        cmp_low_acc;

  assign addr        = apb_req.paddr;
  assign setup       = apb_req.psel & ~apb_req.penable;
  assign acc         = apb_req.psel & apb_req.penable;
  assign wr          = acc & apb_req.pwrite;
  assign rd          = acc & ~apb_req.pwrite;
  assign cnt_low_wr  = wr & (addr == ADDR_CNT_LOW);
  assign clk_sel     = q.ctl_two[C2_CLK_LSB +: 2];
  assign pwm_active  = q.ctl_two[C2_PWM];
  assign opm_active  = q.ctl_two[C2_OPM] & ~pwm_active;
  assign capture_off = q.ctl_two[C2_OPM] | pwm_active;
  assign force_allowed = ~capture_off;
  assign cnt_inc     = q.cnt + 16'h0001;

  // ****************************************************************
  // Timer clock
  // ****************************************************************
  // External clock edges come from the second and third sync stages
  assign ext_edge = q.ctl_two[C2_EXT_EDGE] ?
                    (q.ext_sync[1] & ~q.ext_sync[2]) :
                    (~q.ext_sync[1] & q.ext_sync[2]);

  always_comb begin
    case (clk_sel)
      CLK_DIV2: tick = q.psc[0];
      CLK_DIV4: tick = &q.psc[1:0];
      CLK_DIV8: tick = &q.psc;
      CLK_EXT:  tick = ext_edge;
      default:  tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // Per-channel edge detect and compare
  // ****************************************************************
  genvar g;
  for (g = 0; g < 2; g++) begin : g_chan
    logic [2:0]  s;
    logic        edge_rise;
    logic [15:0] tgt;
    assign s = q.cap_sync[g];
    // Edge select bit picks the sampled transition: rising when set, falling when clear
    assign edge_rise = (g == 0) ? q.ctl_one[C1_EDGE1] : q.ctl_two[C2_EDGE2];
    assign cap_edge[g] = edge_rise ? (s[1] & ~s[2]) : (~s[1] & s[2]);
    assign cap_fire[g] = cap_edge[g] & ~q.cap_lock[g] &
                         ((g == 1) | ~capture_off);
    // Slower clocks see the match one count late
    assign tgt = (clk_sel == CLK_DIV2) ? q.cmp[g] :
                 q.cmp[g] + 16'h0001;
    assign cmp_hit[g] = tick & ~opm_fire & ~cnt_low_wr & ~q.cmp_lock[g] &
                        (cnt_inc == tgt);
    assign cap_low_acc[g] = acc & (addr == ADDR_CAP_LOW[g]);
    assign cmp_low_acc[g] = acc & (addr == ADDR_CMP_LOW[g]);
  end

  assign opm_fire = opm_active & cap_edge[0];

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    mapped = 1'b1;
    case (addr)
      ADDR_CTRL_ONE:  rdata = q.ctl_one;
      ADDR_CTRL_TWO:  rdata = q.ctl_two;
      ADDR_STATUS:    rdata = {q.cap_flag[0], q.cmp_flag[0], 1'b0,
                               q.cap_flag[1], q.cmp_flag[1], 3'h0};
      ADDR_CAP1_HIGH: rdata = q.cap[0][15:8];
      ADDR_CAP1_LOW:  rdata = q.cap[0][7:0];
      ADDR_CMP1_HIGH: rdata = q.cmp[0][15:8];
      ADDR_CMP1_LOW:  rdata = q.cmp[0][7:0];
      ADDR_CAP2_HIGH: rdata = q.cap[1][15:8];
      ADDR_CAP2_LOW:  rdata = q.cap[1][7:0];
      ADDR_CMP2_HIGH: rdata = q.cmp[1][15:8];
      ADDR_CMP2_LOW:  rdata = q.cmp[1][7:0];
      ADDR_CNT_HIGH:  rdata = q.cnt[15:8];
      ADDR_CNT_LOW:   rdata = q.cnt[7:0];
      default: begin
        rdata  = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.ext_sync = {q.ext_sync[1:0], external_timer_clock_pin};
    d.psc = q.psc + 3'h1;
    // Read data is frozen in setup so arming matches what was seen
    if (setup) begin
      d.prdata = {24'h000000, rdata};
    end
    if (tick) begin
      d.cnt = cnt_inc;
    end
    if (cnt_low_wr) begin
      d.cnt = CNT_RESET;
    end
    if (wr && addr == ADDR_CTRL_TWO) begin
      d.ctl_two = apb_req.pwdata[7:0];
    end
    if (wr && addr == ADDR_CTRL_ONE) begin
      d.ctl_one = apb_req.pwdata[7:0] & CTRL_ONE_WMASK;
    end
    for (int i = 0; i < 2; i++) begin
      d.cap_sync[i] = {q.cap_sync[i][1:0], capture_pin[i]};
      // Software side: arm, lock and clear
      if (rd && addr == ADDR_STATUS) begin
        d.cap_arm[i] = q.cap_arm[i] | q.prdata[ST_CAP[i]];
        d.cmp_arm[i] = q.cmp_arm[i] | q.prdata[ST_CMP[i]];
      end
      if (rd && addr == ADDR_CAP_HIGH[i]) begin
        d.cap_lock[i] = 1'b1;
      end
      if (cap_low_acc[i] && !apb_req.pwrite) begin
        d.cap_lock[i] = 1'b0;
      end
      if (cap_low_acc[i] && q.cap_arm[i]) begin
        d.cap_flag[i] = 1'b0;
        d.cap_arm[i]  = 1'b0;
      end
      if (wr && addr == ADDR_CMP_HIGH[i]) begin
        d.cmp[i][15:8] = apb_req.pwdata[7:0];
        d.cmp_lock[i]  = 1'b1;
      end
      if (wr && addr == ADDR_CMP_LOW[i]) begin
        d.cmp[i][7:0] = apb_req.pwdata[7:0];
        d.cmp_lock[i] = 1'b0;
      end
      if (cmp_low_acc[i] && q.cmp_arm[i]) begin
        d.cmp_flag[i] = 1'b0;
        d.cmp_arm[i]  = 1'b0;
      end
      // Hardware side comes last so a set beats a clear
      if (cap_fire[i] && !(i == 0 && opm_active)) begin
        d.cap[i]      = q.cnt;
        d.cap_flag[i] = 1'b1;
      end
      if (cmp_hit[i]) begin
        if (!pwm_active && !(i == 0 && opm_active)) begin
          d.cmp_flag[i] = 1'b1;
        end
        if (opm_active) begin
          if (i == 0 && q.one_pulse_select == OPM_PULSE) begin
            d.pin[0] = q.ctl_one[C1_LEVEL1];
            d.one_pulse_select    = OPM_IDLE;
          end
        end else if (!pwm_active && q.ctl_two[C2_OE[i]]) begin
          d.pin[i] = q.ctl_one[C1_LEVEL[i]];
        end
      end
      // Force uses the level being written in the same access
      if (wr && addr == ADDR_CTRL_ONE && force_allowed &&
          apb_req.pwdata[C1_FORCE[i]] && q.ctl_two[C2_OE[i]]) begin
        d.pin[i] = apb_req.pwdata[C1_LEVEL[i]];
      end
    end
    if (opm_fire) begin
      d.cnt         = CNT_RESET;
      d.pin[0]      = q.ctl_one[C1_LEVEL2];
      d.cap_flag[0] = 1'b1;
      d.cap[0]      = CAP_ONE_PULSE;
      d.one_pulse_select         = OPM_PULSE;
    end
    if (!opm_active) begin
      d.one_pulse_select = OPM_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Zero-wait slave: every access completes in its first access cycle
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~mapped;

  assign compare_out_pin    = q.pin;
  assign compare_out_pin_oe = {q.ctl_two[C2_OE[1]], q.ctl_two[C2_OE[0]]};

  // Pending flags wait here until enable and mask allow them out
  assign timer_irq = ~cpu_irq_mask &
                     ((|q.cap_flag & q.ctl_one[C1_CAP_IE]) |
                      (|q.cmp_flag & q.ctl_one[C1_CMP_IE]));

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_status_seen_cap1;
    rd && addr == ADDR_STATUS && q.prdata[ST_CAP[0]];
  endsequence

  sequence s_pulse_end;
    opm_active && q.one_pulse_select == OPM_PULSE && cmp_hit[0];
  endsequence

  property p_cnt_step;
    tick && !opm_fire && !cnt_low_wr |=> q.cnt == $past(q.cnt) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter did not advance on tick");

  property p_div2_rate;
    (tick && clk_sel == CLK_DIV2) ##2 (clk_sel == CLK_DIV2) |-> tick;
  endproperty
  a_div2_rate: assert property (p_div2_rate)
    else $error("divide-by-two tick spacing wrong");

  property p_cap_load;
    cap_fire[1] |=> q.cap[1] == $past(q.cnt) && q.cap_flag[1];
  endproperty
  a_cap_load: assert property (p_cap_load)
    else $error("capture two did not latch counter");

  property p_cap_irq;
    $rose(q.cap_flag[0]) && q.ctl_one[C1_CAP_IE] && !cpu_irq_mask
      |-> timer_irq;
  endproperty
  a_cap_irq: assert property (p_cap_irq)
    else $error("capture interrupt not raised");

  property p_cap_clear;
    $fell(q.cap_flag[0]) |-> $past(q.cap_arm[0] && cap_low_acc[0]);
  endproperty
  a_cap_clear: assert property (p_cap_clear)
    else $error("capture flag cleared without sequence");

  property p_cap_arm;
    s_status_seen_cap1 |=> q.cap_arm[0];
  endproperty
  a_cap_arm: assert property (p_cap_arm)
    else $error("status read did not arm capture flag");

  property p_cap_lock;
    $rose(q.cap_flag[1]) |-> $past(!q.cap_lock[1]);
  endproperty
  a_cap_lock: assert property (p_cap_lock)
    else $error("capture flag set while locked");

  property p_cmp_clear;
    $fell(q.cmp_flag[1]) |-> $past(q.cmp_arm[1] && cmp_low_acc[1]);
  endproperty
  a_cmp_clear: assert property (p_cmp_clear)
    else $error("compare flag cleared without sequence");

  property p_cmp_lock;
    $rose(q.cmp_flag[1]) |-> $past(!q.cmp_lock[1]);
  endproperty
  a_cmp_lock: assert property (p_cmp_lock)
    else $error("compare flag set while compare inhibited");

  property p_cmp_time;
    $rose(q.cmp_flag[1]) |-> q.cnt == (($past(clk_sel) == CLK_DIV2) ?
      $past(q.cmp[1]) : $past(q.cmp[1]) + 16'h0001);
  endproperty
  a_cmp_time: assert property (p_cmp_time)
    else $error("compare flag at wrong counter value");

  property p_opm_start;
    opm_fire |=> q.cnt == CNT_RESET && q.cap[0] == CAP_ONE_PULSE &&
      q.cap_flag[0] && q.pin[0] == $past(q.ctl_one[C1_LEVEL2]);
  endproperty
  a_opm_start: assert property (p_opm_start)
    else $error("one-pulse start wrong");

  property p_opm_end;
    s_pulse_end |=> q.pin[0] == $past(q.ctl_one[C1_LEVEL1]) &&
      q.one_pulse_select == OPM_IDLE;
  endproperty
  a_opm_end: assert property (p_opm_end)
    else $error("one-pulse end wrong");

  property p_opm_no_flag;
    $rose(q.cmp_flag[0]) |-> !$past(opm_active) && !$past(pwm_active);
  endproperty
  a_opm_no_flag: assert property (p_opm_no_flag)
    else $error("compare flag one set in one-pulse mode");

  property p_force;
    wr && addr == ADDR_CTRL_ONE && force_allowed && q.ctl_two[C2_OE[0]] &&
      apb_req.pwdata[C1_FORCE[0]]
      |=> q.pin[0] == $past(apb_req.pwdata[C1_LEVEL[0]]);
  endproperty
  a_force: assert property (p_force)
    else $error("forced level not on pin");

  property p_cap1_off;
    capture_off && cap_edge[0] && !opm_fire |=> q.cap[0] == $past(q.cap[0]);
  endproperty
  a_cap1_off: assert property (p_cap1_off)
    else $error("capture one active in pulse or PWM mode");

endmodule

`default_nettype wire

/* File: timer_pin_partner.sv */
// Behavioural signal sources and loads on the timer pins
`timescale 1ns/10ps
`default_nettype none

module timer_pin_partner (
  // Clock
  input  wire logic       sys_clk,
  // Timer pins
  output logic [1:0]      capture_pin,
  output logic            external_timer_clock_pin,
  input  wire logic [1:0] compare_out_pin,
  input  wire logic [1:0] compare_out_pin_oe,
  // Pad levels seen by the load
  output logic [1:0]      pad_level
);
  // Undriven compare pads float high through a pull-up
  assign pad_level = (compare_out_pin & compare_out_pin_oe)
                   | ~compare_out_pin_oe;

  initial begin
    capture_pin = 2'h0;
    external_timer_clock_pin = 1'b0;
  end

  // Held well past the synchroniser and edge stage
  task automatic set_cap(input int ch, input logic lvl);
    @(posedge sys_clk);
    capture_pin[ch] <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask

  // Edges kept more than four cycles apart, as the counter needs
  task automatic ext_pulses(input int cnt);
    repeat (cnt) begin
      @(posedge sys_clk);
      external_timer_clock_pin <= 1'b1;
      repeat (5) @(posedge sys_clk);
      external_timer_clock_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule

`default_nettype wire

/* File: timer_pkg.sv */
// Register map, field positions and state types of the capture/compare timer
package timer_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL_ONE  = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_TWO  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_CAP1_HIGH = 8'h0c;
  localparam logic [7:0]  ADDR_CAP1_LOW  = 8'h10;
  localparam logic [7:0]  ADDR_CMP1_HIGH = 8'h14;
  localparam logic [7:0]  ADDR_CMP1_LOW  = 8'h18;
  localparam logic [7:0]  ADDR_CAP2_HIGH = 8'h1c;
  localparam logic [7:0]  ADDR_CAP2_LOW  = 8'h20;
  localparam logic [7:0]  ADDR_CMP2_HIGH = 8'h24;
  localparam logic [7:0]  ADDR_CMP2_LOW  = 8'h28;
  localparam logic [7:0]  ADDR_CNT_HIGH  = 8'h2c;
  localparam logic [7:0]  ADDR_CNT_LOW   = 8'h30;
  localparam logic [1:0][7:0] ADDR_CAP_HIGH = {ADDR_CAP2_HIGH, ADDR_CAP1_HIGH};
  localparam logic [1:0][7:0] ADDR_CAP_LOW  = {ADDR_CAP2_LOW, ADDR_CAP1_LOW};
  localparam logic [1:0][7:0] ADDR_CMP_HIGH = {ADDR_CMP2_HIGH, ADDR_CMP1_HIGH};
  localparam logic [1:0][7:0] ADDR_CMP_LOW  = {ADDR_CMP2_LOW, ADDR_CMP1_LOW};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned C1_LEVEL1 = 0;
  localparam int unsigned C1_LEVEL2 = 1;
  localparam int unsigned C1_EDGE1  = 2;
  localparam int unsigned C1_CMP_IE = 6;
  localparam int unsigned C1_CAP_IE = 7;
  localparam int unsigned C1_LEVEL [2] = '{0, 1};
  localparam int unsigned C1_FORCE [2] = '{3, 4};
  localparam int unsigned C2_EXT_EDGE = 0;
  localparam int unsigned C2_EDGE2    = 1;
  localparam int unsigned C2_CLK_LSB  = 2;
  localparam int unsigned C2_PWM      = 4;
  localparam int unsigned C2_OPM      = 5;
  localparam int unsigned C2_OE [2]   = '{7, 6};
  localparam int unsigned ST_CAP [2]  = '{7, 4};
  localparam int unsigned ST_CMP [2]  = '{6, 3};
  localparam logic [7:0]  CTRL_ONE_WMASK = 8'hc7;

  // ****************************************************************
  // Encodings and values after reset
  // ****************************************************************
  localparam logic [1:0]  CLK_DIV4 = 2'h0;
  localparam logic [1:0]  CLK_DIV2 = 2'h1;
  localparam logic [1:0]  CLK_DIV8 = 2'h2;
  localparam logic [1:0]  CLK_EXT  = 2'h3;
  localparam logic [15:0] CNT_RESET     = 16'hfffc;
  localparam logic [15:0] CAP_ONE_PULSE = 16'hfffd;
  localparam logic [15:0] CMP_RESET     = 16'h8000;
  localparam logic [15:0] CAP_RESET     = 16'h0000;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [2:0]  PSC_RESET     = 3'h0;
  localparam logic [2:0]  SYNC_RESET    = 3'h0;

  typedef enum logic {OPM_IDLE = 1'b0, OPM_PULSE = 1'b1} opm_state_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [7:0]       ctl_one;
    logic [7:0]       ctl_two;
    logic [15:0]      cnt;
    logic [2:0]       psc;
    logic [1:0][15:0] cap;
    logic [1:0][15:0] cmp;
    logic [1:0]       cap_flag;
    logic [1:0]       cmp_flag;
    logic [1:0]       cap_arm;
    logic [1:0]       cmp_arm;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_lock;
    logic [1:0]       pin;
    logic [1:0][2:0]  cap_sync;
    logic [2:0]       ext_sync;
    opm_state_e       one_pulse_select;
    logic [31:0]      prdata;
  } timer_state_s;

  localparam timer_state_s STATE_RESET = '{
    ctl_one: CTRL_RESET, ctl_two: CTRL_RESET, cnt: CNT_RESET,
    psc: PSC_RESET, cap: {CAP_RESET, CAP_RESET},
    cmp: {CMP_RESET, CMP_RESET}, cap_flag: 2'h0, cmp_flag: 2'h0,
    cap_arm: 2'h0, cmp_arm: 2'h0, cap_lock: 2'h0, cmp_lock: 2'h0,
    pin: 2'h0, cap_sync: {SYNC_RESET, SYNC_RESET}, ext_sync: SYNC_RESET,
    one_pulse_select: OPM_IDLE, prdata: 32'h0000_0000};

endpackage
